/* atic_pkg.sv */
package atic_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_LOW_LIMIT_LO = 8'h84;
  localparam logic [7:0] ADDR_LOW_LIMIT_HI = 8'h85;
  localparam logic [7:0] ADDR_HIGH_LIMIT_LO = 8'h86;
  localparam logic [7:0] ADDR_HIGH_LIMIT_HI = 8'h87;
  localparam logic [7:0] ADDR_PERSISTENCE = 8'h8c;
  localparam logic [7:0] ADDR_WAIT_CONFIG = 8'h8d;
  localparam logic [7:0] ADDR_GAIN_MUX_CONFIG = 8'h90;
  localparam logic [7:0] ADDR_REVISION_CODE = 8'h91;
  localparam logic [7:0] ADDR_PART_CODE = 8'h92;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h93;
  // ==========================================================
  // field positions
  localparam int WAIT_LONG_BIT = 2;
  localparam int CH3_SOURCE_BIT = 3;
  localparam int SAT_FLAG_BIT = 7;
  localparam int INT_FLAG_BIT = 4;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_WAIT_CONFIG = 8'h80;
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  // arbitrary identity values, no meaning
  localparam logic [4:0] REV_UPPER = 5'h00;
  localparam logic [2:0] REV_NUMBER = 3'h0;
  localparam logic [5:0] PART_NUMBER = 6'h2a;
  // ==========================================================
  // timing
  localparam logic [3:0] WAIT_LONG_FACTOR = 4'hc;
  localparam logic [5:0] INTERRUPT_PERSISTENCE_STEP = 6'h05;
  localparam logic [3:0] INTERRUPT_PERSISTENCE_LINEAR_MAX = 4'h3;
  // ==========================================================
  // gain selection
  typedef enum logic [1:0] {
    ATIC_GAIN_1X = 2'b00,
    ATIC_GAIN_4X = 2'b01,
    ATIC_GAIN_16X = 2'b10,
    ATIC_GAIN_64X = 2'b11
  } atic_gain_t;
endpackage

/* atic_limit_pair.sv */
`timescale 1ns/10ps
// two-byte limit with shared low-byte latch
module atic_limit_pair (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // write strobes
  input wire logic wr_hi,
  input wire logic [7:0] staged_lo,
  input wire logic [7:0] wr_data,
  // limit
  output logic [15:0] limit
);
  // ==========================================================
  // whole value updates only on the high byte
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      limit <= atic_pkg::RST_LIMIT;
    end else if (wr_hi) begin
      limit <= {wr_data, staged_lo};
    end
  end
endmodule

/* atic_persist.sv */
`timescale 1ns/10ps
// persistence filter on channel-0 results
module atic_persist (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration
  input wire logic [3:0] persistence_count_sel,
  input wire logic [15:0] low_limit,
  input wire logic [15:0] high_limit,
  // result strobe
  input wire logic ch0_valid,
  input wire logic [15:0] ch0_data,
  // event
  output logic fire
);
  logic out_of_window;
  logic [5:0] need;
  logic [5:0] run_reg;
  logic [5:0] run_next;
  // ==========================================================
  // required count
  always_comb begin
    out_of_window = (ch0_data > high_limit) || (ch0_data < low_limit);
    if (persistence_count_sel <= atic_pkg::INTERRUPT_PERSISTENCE_LINEAR_MAX) begin
      need = {2'b00, persistence_count_sel};
    end else begin
      need = 6'((persistence_count_sel - atic_pkg::INTERRUPT_PERSISTENCE_LINEAR_MAX) * atic_pkg::INTERRUPT_PERSISTENCE_STEP);
    end
    run_next = (run_reg == 6'h3f) ? run_reg : 6'(run_reg + 6'h01);
  end
  // ==========================================================
  // run counter
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_reg <= 6'h00;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (ch0_valid) begin
        if (persistence_count_sel == 4'h0) begin
          fire <= 1'b1;
        end else if (out_of_window) begin
          run_reg <= run_next;
          fire <= (run_next >= need);
        end else begin
          run_reg <= 6'h00;
        end
      end
    end
  end
endmodule

/* atic_core.sv */
// Operation
// - high limit low and high bytes form one sixteen-bit upper limit
// - result above upper limit with persistence met sets flag, drives pin if enabled
// - persistence zero interrupts at every integration end
// - persistence one interrupts on any single out-of-window result
// - persistence two and three need that many consecutive outliers
// - persistence four to fifteen need five times (value minus three) outliers
// - only channel-0 results feed the interrupt
// - wait-long bit stretches each wait cycle twelve times
// - configuration bit 3 picks channel-3 source, zero selects X
// - two-bit gain field picks 1x, 4x, 16x or 64x
// - saturation sets status bit 7, host write of one clears
// - status bit 4 shows interrupt, host write of one clears
// - result below lower limit with persistence met sets flag
// - low byte latched until high byte write applies both
// - multiplexer bit three routes second infrared result to channel 3
`timescale 1ns/10ps
module atic_core (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // measurement side
  input wire logic int_enable,
  input wire logic ch0_valid,
  input wire logic [15:0] ch0_data,
  input wire logic saturation_in,
  input wire logic [15:0] x_data,
  input wire logic [15:0] ir2_data,
  input wire logic [7:0] wait_duration,
  // derived controls
  output logic [11:0] wait_cycles,
  output logic [15:0] ch3_data,
  output logic [1:0] gain_sel,
  output logic [6:0] gain_factor,
  // interrupt pin, open drain
  output logic int_n_out,
  output logic int_n_oe
);
  logic [7:0] staged_lo_reg;
  logic [7:0] persistence_reg;
  logic [7:0] wait_config_reg;
  logic [7:0] gain_mux_config_reg;
  logic saturation_flag_reg;
  logic int_flag_reg;
  logic sat_meta_reg;
  logic sat_sync_reg;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic fire;
  logic wr_low_hi;
  logic wr_high_hi;
  logic clr_sat;
  logic clr_int;
  logic [7:0] rd_next;

  assign wr_low_hi = reg_wr && (reg_addr == atic_pkg::ADDR_LOW_LIMIT_HI);
  assign wr_high_hi = reg_wr && (reg_addr == atic_pkg::ADDR_HIGH_LIMIT_HI);
  assign clr_sat = reg_wr && (reg_addr == atic_pkg::ADDR_EVENT_FLAGS)
    && reg_wdata[atic_pkg::SAT_FLAG_BIT];
  assign clr_int = reg_wr && (reg_addr == atic_pkg::ADDR_EVENT_FLAGS)
    && reg_wdata[atic_pkg::INT_FLAG_BIT];

  // ==========================================================
  // limits
  atic_limit_pair u_low (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_hi(wr_low_hi),
    .staged_lo(staged_lo_reg),
    .wr_data(reg_wdata),
    .limit(low_limit)
  );

  atic_limit_pair u_high (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_hi(wr_high_hi),
    .staged_lo(staged_lo_reg),
    .wr_data(reg_wdata),
    .limit(high_limit)
  );

  // ==========================================================
  // persistence filter, channel 0 only
  atic_persist u_persist (
    .clock(clock),
    .sys_rst(sys_rst),
    .persistence_count_sel(persistence_reg[3:0]),
    .low_limit(low_limit),
    .high_limit(high_limit),
    .ch0_valid(ch0_valid),
    .ch0_data(ch0_data),
    .fire(fire)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      staged_lo_reg <= atic_pkg::RST_BYTE;
      persistence_reg <= atic_pkg::RST_BYTE;
      wait_config_reg <= atic_pkg::RST_WAIT_CONFIG;
      gain_mux_config_reg <= atic_pkg::RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        atic_pkg::ADDR_LOW_LIMIT_LO, atic_pkg::ADDR_HIGH_LIMIT_LO: begin
          staged_lo_reg <= reg_wdata;
        end
        atic_pkg::ADDR_PERSISTENCE: begin
          persistence_reg <= reg_wdata;
        end
        atic_pkg::ADDR_WAIT_CONFIG: begin
          wait_config_reg <= reg_wdata;
        end
        atic_pkg::ADDR_GAIN_MUX_CONFIG: begin
          gain_mux_config_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // saturation input synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sat_meta_reg <= 1'b0;
      sat_sync_reg <= 1'b0;
    end else begin
      sat_meta_reg <= saturation_in;
      sat_sync_reg <= sat_meta_reg;
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      saturation_flag_reg <= 1'b0;
      int_flag_reg <= 1'b0;
    end else begin
      if (sat_sync_reg) begin
        saturation_flag_reg <= 1'b1;
      end else if (clr_sat) begin
        saturation_flag_reg <= 1'b0;
      end
      if (fire) begin
        int_flag_reg <= 1'b1;
      end else if (clr_int) begin
        int_flag_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      int_n_out <= 1'b0;
      int_n_oe <= 1'b0;
    end else begin
      // open drain: data stays low, only the enable moves
      int_n_out <= 1'b0;
      int_n_oe <= int_flag_reg && int_enable;
    end
  end

  // ==========================================================
  // derived controls
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_cycles <= 12'h001;
      ch3_data <= 16'h0000;
      gain_sel <= 2'b00;
      gain_factor <= 7'h01;
    end else begin
      if (wait_config_reg[atic_pkg::WAIT_LONG_BIT]) begin
        wait_cycles <= 12'(({4'h0, wait_duration} + 12'h001) * atic_pkg::WAIT_LONG_FACTOR);
      end else begin
        wait_cycles <= {4'h0, wait_duration} + 12'h001;
      end
      ch3_data <= gain_mux_config_reg[atic_pkg::CH3_SOURCE_BIT] ? ir2_data : x_data;
      gain_sel <= gain_mux_config_reg[1:0];
      case (atic_pkg::atic_gain_t'(gain_mux_config_reg[1:0]))
        atic_pkg::ATIC_GAIN_1X: gain_factor <= 7'h01;
        atic_pkg::ATIC_GAIN_4X: gain_factor <= 7'h04;
        atic_pkg::ATIC_GAIN_16X: gain_factor <= 7'h10;
        atic_pkg::ATIC_GAIN_64X: gain_factor <= 7'h40;
        default: gain_factor <= 7'h01;
      endcase
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    case (reg_addr)
      atic_pkg::ADDR_LOW_LIMIT_LO: rd_next = low_limit[7:0];
      atic_pkg::ADDR_LOW_LIMIT_HI: rd_next = low_limit[15:8];
      atic_pkg::ADDR_HIGH_LIMIT_LO: rd_next = high_limit[7:0];
      atic_pkg::ADDR_HIGH_LIMIT_HI: rd_next = high_limit[15:8];
      atic_pkg::ADDR_PERSISTENCE: rd_next = persistence_reg;
      atic_pkg::ADDR_WAIT_CONFIG: rd_next = wait_config_reg;
      atic_pkg::ADDR_GAIN_MUX_CONFIG: rd_next = gain_mux_config_reg;
      atic_pkg::ADDR_REVISION_CODE: rd_next = {atic_pkg::REV_UPPER, atic_pkg::REV_NUMBER};
      atic_pkg::ADDR_PART_CODE: rd_next = {atic_pkg::PART_NUMBER, 2'b00};
      atic_pkg::ADDR_EVENT_FLAGS: rd_next = {saturation_flag_reg, 2'b00, int_flag_reg, 4'h0};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_next;
    end
  end
endmodule

/* atic_core_props.sv */
`timescale 1ns/10ps
// ============================================================
// port checker for the core
module atic_core_props (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // measurement side
  input wire logic int_enable,
  input wire logic ch0_valid,
  input wire logic [15:0] x_data,
  input wire logic [15:0] ir2_data,
  input wire logic [7:0] wait_duration,
  // derived controls
  input wire logic [11:0] wait_cycles,
  input wire logic [15:0] ch3_data,
  input wire logic [1:0] gain_sel,
  input wire logic [6:0] gain_factor,
  // interrupt pin
  input wire logic int_n_out,
  input wire logic int_n_oe
);
  logic [7:0] wcfg_reg;
  logic [7:0] gmux_reg;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // shadow of the wait and gain/multiplexer configuration writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wcfg_reg <= atic_pkg::RST_WAIT_CONFIG;
      gmux_reg <= 8'h00;
    end else if (reg_wr && reg_addr == atic_pkg::ADDR_WAIT_CONFIG) begin
      wcfg_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == atic_pkg::ADDR_GAIN_MUX_CONFIG) begin
      gmux_reg <= reg_wdata;
    end
  end
  a_pin_data_low: assert property (int_n_out == 1'b0)
    else $error("pin data not low");
  a_oe_needs_enable: assert property (int_n_oe |-> $past(int_enable))
    else $error("pin driven while disabled");
  a_oe_rise_cause: assert property (
    $rose(int_n_oe) |-> $past(ch0_valid, 3) || !$past(int_enable, 2))
    else $error("pin rose without a result");
  a_oe_fall_cause: assert property (
    $fell(int_n_oe) |-> !$past(int_enable) || ($past(reg_wr, 2)
      && $past(reg_addr, 2) == atic_pkg::ADDR_EVENT_FLAGS
      && $past(reg_wdata[atic_pkg::INT_FLAG_BIT], 2)))
    else $error("pin released without a clear");
  a_ch3_source: assert property (
    ch3_data == ($past(gmux_reg[3]) ? $past(ir2_data) : $past(x_data)))
    else $error("channel 3 source wrong");
  a_gain_field: assert property (
    $stable(gmux_reg) [*2] |-> gain_sel == gmux_reg[1:0])
    else $error("gain field wrong");
  a_gain_factor_map: assert property (
    $stable(gmux_reg) [*2] |-> gain_factor == 7'h01 << {gmux_reg[1:0], 1'b0})
    else $error("gain factor wrong");
  a_wait_scale: assert property (
    $stable({wcfg_reg, wait_duration}) [*2] |-> wait_cycles ==
      ({4'h0, wait_duration} + 12'h001) * (wcfg_reg[2] ? 12'h00c : 12'h001))
    else $error("wait cycles wrong");
  a_part_code_read: assert property (
    reg_rd && reg_addr == atic_pkg::ADDR_PART_CODE |=>
      reg_rdata == {atic_pkg::PART_NUMBER, 2'b00})
    else $error("part code wrong");
endmodule
bind atic_core atic_core_props u_props (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .int_enable, .ch0_valid, .x_data, .ir2_data, .wait_duration,
  .wait_cycles, .ch3_data, .gain_sel, .gain_factor, .int_n_out, .int_n_oe);

/* atic_host.sv */
`timescale 1ns/10ps
// ============================================================
// host side of the register port
module atic_host (
  // clock
  input wire logic clock,
  // register port
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // one byte access taken at one edge, lines scrambled when idle
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

/* atic_core_test.sv */
`timescale 1ns/10ps
// ============================================================
// self-checking bench for the core
module atic_core_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic int_enable = 1'b1;
  logic ch0_valid = 1'b0;
  logic saturation_in = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] wait_duration = 8'h00;
  logic [15:0] ch0_data = 16'h0000;
  logic [15:0] x_data = 16'h0000;
  logic [15:0] ir2_data = 16'h0000;
  logic [15:0] seed = 16'h003c;
  logic reg_wr, reg_rd, int_n_out, int_n_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [11:0] wait_cycles;
  logic [15:0] ch3_data;
  logic [1:0] gain_sel;
  logic [6:0] gain_factor;
  logic [7:0] exp_q[$];
  logic [3:0] interrupt_persistence_list[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
  int n_mismatch = 0;
  int check_count = 0;
  int need;
  atic_host host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  atic_core dut (.clock, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .int_enable, .ch0_valid, .ch0_data, .saturation_in, .x_data, .ir2_data, .wait_duration,
    .wait_cycles, .ch3_data, .gain_sel, .gain_factor, .int_n_out, .int_n_oe);
  initial forever #5 clock = ~clock;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
    check_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  // one channel-0 result, other channels random
  task automatic res(input logic [15:0] v);
    seed = lfsr(seed);
    @(posedge clock);
    ch0_valid <= 1'b1;
    ch0_data <= v;
    x_data <= seed;
    ir2_data <= ~seed;
    @(posedge clock);
    ch0_valid <= 1'b0;
    ch0_data <= ~v;
    repeat (3) @(posedge clock);
  endtask
  // read data checker
  always @(posedge clock) begin
    if (rd_d) cmp8(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'h8c, 8'h00);
    rd(8'h8d, 8'h80);
    rd(8'h93, 8'h00);
    rd(8'h91, {atic_pkg::REV_UPPER, atic_pkg::REV_NUMBER});
    wr(8'h92, 8'hff);
    rd(8'h92, {atic_pkg::PART_NUMBER, 2'b00});
    rd(8'ha0, 8'h00);
    wr(8'h86, 8'h34);
    rd(8'h86, 8'h00);
    wr(8'h87, 8'h02);
    rd(8'h86, 8'h34);
    rd(8'h87, 8'h02);
    for (int g = 0; g < 8; g++) begin
      wr(8'h90, {4'h0, g[2], 1'b0, g[1:0]});
      rd(8'h90, {4'h0, g[2], 1'b0, g[1:0]});
      wait_duration <= seed[7:0];
      wr(8'h8d, {5'b10000, g[0], 2'b00});
      res(16'h0150);
    end
    wr(8'h84, 8'h00);
    wr(8'h85, 8'h01);
    foreach (interrupt_persistence_list[i]) begin
      need = (interrupt_persistence_list[i] < 4) ? interrupt_persistence_list[i] : 5 * (interrupt_persistence_list[i] - 3);
      int_enable <= (i != 1);
      wr(8'h8c, {4'h0, interrupt_persistence_list[i]});
      // in-window result ends any run left from the previous setting
      res(16'h0150);
      wr(8'h93, 8'hff);
      if (need > 1) res(16'hffff);
      if (need > 1) res(16'h0150);
      for (int k = 1; k < need; k++) res(k[0] ? 16'h0235 + seed[7:0] : {8'h00, seed[7:0]});
      rd(8'h93, 8'h00);
      res(need == 0 ? 16'h0150 : 16'hffff);
      rd(8'h93, 8'h10);
      cmp8({7'h00, int_n_oe}, {7'h00, i != 1});
    end
    wr(8'h93, 8'hff);
    saturation_in <= 1'b1;
    repeat (2) @(posedge clock);
    saturation_in <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h93, 8'h80);
    wr(8'h93, 8'h80);
    rd(8'h93, 8'h00);
    cmp8({7'h00, int_n_oe}, 8'h00);
    repeat (3) @(posedge clock);
    tally_and_finish();
  end
endmodule
